// ### design/pin_function_pkg.sv
// shared constants of the pin function selection block
package pin_function_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_DIR_A = 8'h00;
	localparam logic [7:0] OFS_DIR_B = 8'h04;
	localparam logic [7:0] OFS_DATA_A = 8'h08;
	localparam logic [7:0] OFS_DATA_B = 8'h0C;
	localparam logic [7:0] OFS_PIN_A = 8'h10;
	localparam logic [7:0] OFS_PIN_B = 8'h14;
	localparam logic [7:0] OFS_ANS_A = 8'h18;
	localparam logic [7:0] OFS_ANS_B = 8'h1C;
	localparam logic [7:0] OFS_PU_A = 8'h20;
	localparam logic [7:0] OFS_PU_B = 8'h24;
	localparam logic [7:0] OFS_IOC_A = 8'h28;
	localparam logic [7:0] OFS_IOC_B = 8'h2C;
	localparam logic [7:0] OFS_STAT = 8'h30;
	localparam logic [7:0] OFS_MASK = 8'h34;
	localparam logic [7:0] OFS_MODE = 8'h38;
	localparam logic [7:0] OFS_DBG = 8'h3C;
	localparam logic [7:0] OFS_CONV = 8'h40;
	localparam logic [7:0] OFS_OPT = 8'h44;
	localparam logic [7:0] OFS_PE1 = 8'h48;
	localparam logic [4:0] NUM_REGS = 5'h13;
	// reset values
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam logic [7:0] CLEAR_RESET = 8'h00;
	localparam logic [16:0] STAT_RESET = 17'h00000;
	// field positions
	localparam int DBG_EN_BIT = 0;
	localparam int DBG_ANALOG_BIT = 1;
	localparam int DBG_SEL_LSB = 4;
	localparam int CONV_SRC_LSB = 0;
	localparam int OPT_TIMER_ZERO_SOURCE_BIT_BIT = 0;
	localparam int OPT_EXT_INTERRUPT_ENABLE_BIT_BIT = 1;
	localparam int OPT_MASTER_CLEAR_ENABLE_BIT_BIT = 2;
	localparam int OPT_TWI_BIT = 3;
	localparam int PE1_SPU_BIT = 1;
	localparam int PE1_DESAT_BIT = 2;
	localparam int PE1_FBRES_BIT = 3;
	localparam int ROLE_LSB = 0;
	localparam int STAT_EXT_BIT = 16;
	// sync_role_field encodings
	localparam logic [1:0] ROLE_STANDALONE = 2'h0;
	localparam logic [1:0] ROLE_MASTER = 2'h1;
	localparam logic [1:0] ROLE_SLAVE = 2'h2;
	// pin positions in the joined {port b, port a} vector
	localparam int PIN_DBG = 0;
	localparam int PIN_SYNC = 1;
	localparam int PIN_T0 = 2;
	localparam int PIN_EXTERNAL_RESET_INPUT = 5;
	localparam int PIN_SCL = 7;
	localparam int PIN_SDA = 8;
	localparam int PIN_VREF = 9;
	localparam logic [15:0] OPEN_DRAIN_MASK = 16'h0180;
	localparam logic [15:0] INPUT_ONLY_MASK = 16'h0020;
	// converter channel n -> pin position
	localparam logic [7:0][3:0] CHAN_PIN = {4'hE, 4'hD, 4'hC, 4'h9,
		4'h3, 4'h2, 4'h1, 4'h0};
endpackage

// ### design/pin_drive_cell.sv
// output driver selection for one port pin
`timescale 1ns/10ps
module pin_drive_cell (
	// software setting
	input wire logic dir_in,
	input wire logic data_in,
	// alternate function claim
	input wire logic alt_en_in,
	input wire logic alt_val_in,
	// pad kind and forced release
	input wire logic open_drain_in,
	input wire logic hold_off_in,
	// pad side
	output logic out_out,
	output logic oe_n_out
);
	logic drive_val;
	logic drive_en;

	// alternate function wins over port data; hold keeps driver off
	always_comb
	begin
		drive_val = alt_en_in ? alt_val_in : data_in;
		drive_en = !hold_off_in && (alt_en_in || !dir_in);
		if (open_drain_in)
		begin
			out_out = 1'b0;
			oe_n_out = !(drive_en && !drive_val);
		end
		else
		begin
			out_out = drive_val;
			oe_n_out = !drive_en;
		end
	end
endmodule // pin_drive_cell

// ### design/change_detect.sv
// level change and rising edge detector for port pins
`timescale 1ns/10ps
module change_detect #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// sampled pin levels
	input wire logic [WIDTH-1:0] level_in,
	// one-cycle events
	output logic [WIDTH-1:0] change_out,
	output logic [WIDTH-1:0] rise_out
);
	logic [WIDTH-1:0] prev_r;
	logic armed_r;

	// armed after the first sample, so a high pin at reset is no edge
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			prev_r <= '0;
			armed_r <= 1'b0;
		end
		else
		begin
			prev_r <= level_in;
			armed_r <= 1'b1;
		end
	end

	assign change_out = armed_r ? (level_in ^ prev_r) : '0;
	assign rise_out = armed_r ? (level_in & ~prev_r) : '0;
endmodule // change_detect

// ### design/pin_function_select.sv
// pin function selection for the general-purpose port pins
`timescale 1ns/10ps
module pin_function_select
	import pin_function_pkg::*;
(
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// port a pads
	input wire logic [7:0] port_a_pin_in,
	output logic [7:0] port_a_pin_out,
	output logic [7:0] port_a_pin_oe_n_out,
	output logic [7:0] port_a_pullup_out,
	// port b pads
	input wire logic [7:0] port_b_pin_in,
	output logic [7:0] port_b_pin_out,
	output logic [7:0] port_b_pin_oe_n_out,
	output logic [7:0] port_b_pullup_out,
	// analog routing
	output logic [7:0] adc_channel_connect_out,
	output logic second_reference_output_out,
	output logic debug_analog_connect_out,
	output logic [3:0] debug_analog_source_out,
	// debug monitor sources
	input wire logic [15:0] debug_digital_in,
	// switching frequency sync
	input wire logic sync_clock_gen_in,
	output logic sync_clock_pin_recv_out,
	// timer zero, reset
	output logic timer_zero_ext_clock_out,
	output logic external_reset_input_out,
	// two-wire serial engine
	input wire logic scl_drive_low_in,
	input wire logic sda_drive_low_in,
	output logic scl_level_out,
	output logic sda_level_out,
	// current sense pad control
	output logic sense_input_pullup_out,
	output logic sense_amplifier_output_out,
	output logic desaturation_positive_input_out,
	// interrupt
	output logic irq_out
);
	//--------------------------------------------------
	// register file
	//--------------------------------------------------
	logic [7:0] regs_r [NUM_REGS];
	logic [16:0] status_r;
	logic [16:0] mask_r;
	logic [31:0] prdata_r;
	logic [31:0] rd_nxt;
	logic [4:0] idx;
	logic mapped;
	logic setup;
	logic wr;

	function automatic logic [4:0] idx_of(input logic [7:0] ofs);
		return ofs[6:2];
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && !a[7] && a[6:2] < NUM_REGS;
	endfunction

	// pin levels, status and mask are not in the plain array
	function automatic logic writable(input logic [4:0] i);
		return !(i == idx_of(OFS_PIN_A) || i == idx_of(OFS_PIN_B) ||
			i == idx_of(OFS_STAT) || i == idx_of(OFS_MASK));
	endfunction

	function automatic logic [7:0] reset_of(input logic [4:0] i);
		if (i == idx_of(OFS_DIR_A) || i == idx_of(OFS_DIR_B))
			return DIR_RESET;
		return CLEAR_RESET;
	endfunction

	assign idx = paddr_in[6:2];
	assign mapped = is_mapped(paddr_in);
	assign setup = psel_in && !penable_in;
	assign wr = psel_in && penable_in && pwrite_in && mapped;
	// zero wait states; unmapped access errors in the access phase
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in && penable_in && !mapped;
	assign prdata_out = prdata_r;

	// plain configuration registers
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < int'(NUM_REGS); i++)
				regs_r[i] <= reset_of(5'(i));
		end
		else if (wr && writable(idx))
		begin
			regs_r[idx] <= pwdata_in[7:0];
		end
	end

	//--------------------------------------------------
	// register views
	//--------------------------------------------------
	logic [15:0] pin16;
	logic [15:0] dir16;
	logic [15:0] data16;
	logic [15:0] ans16;
	logic [15:0] pu16;
	logic [15:0] iocen16;
	logic [15:0] gp16;
	logic [7:0] mode_q;
	logic [7:0] dbg_q;
	logic [7:0] opt_q;
	logic [7:0] pe1_q;
	logic [1:0] role;
	logic master;
	logic slave;
	logic dbg_en;
	logic dbg_analog;
	logic master_clear_enable_bit;
	logic twi;

	assign pin16 = {port_b_pin_in, port_a_pin_in};
	assign dir16 = {regs_r[idx_of(OFS_DIR_B)], regs_r[idx_of(OFS_DIR_A)]};
	assign data16 = {regs_r[idx_of(OFS_DATA_B)],
		regs_r[idx_of(OFS_DATA_A)]};
	assign ans16 = {regs_r[idx_of(OFS_ANS_B)], regs_r[idx_of(OFS_ANS_A)]};
	assign pu16 = {regs_r[idx_of(OFS_PU_B)], regs_r[idx_of(OFS_PU_A)]};
	assign iocen16 = {regs_r[idx_of(OFS_IOC_B)],
		regs_r[idx_of(OFS_IOC_A)]};
	assign mode_q = regs_r[idx_of(OFS_MODE)];
	assign dbg_q = regs_r[idx_of(OFS_DBG)];
	assign opt_q = regs_r[idx_of(OFS_OPT)];
	assign pe1_q = regs_r[idx_of(OFS_PE1)];
	// a reserved role code behaves as standalone
	assign role = mode_q[ROLE_LSB +: 2];
	assign master = role == ROLE_MASTER;
	assign slave = role == ROLE_SLAVE;
	assign dbg_en = dbg_q[DBG_EN_BIT];
	assign dbg_analog = dbg_q[DBG_ANALOG_BIT];
	assign master_clear_enable_bit = opt_q[OPT_MASTER_CLEAR_ENABLE_BIT_BIT];
	assign twi = opt_q[OPT_TWI_BIT];
	// pin five reads low while it serves as reset
	assign gp16 = pin16 & ~(master_clear_enable_bit ? INPUT_ONLY_MASK : 16'h0000);

	// read data is captured in the setup phase
	always_comb
	begin
		rd_nxt = 32'h00000000;
		if (mapped)
		begin
			if (idx == idx_of(OFS_PIN_A))
				rd_nxt = {24'h000000, gp16[7:0]};
			else if (idx == idx_of(OFS_PIN_B))
				rd_nxt = {24'h000000, gp16[15:8]};
			else if (idx == idx_of(OFS_STAT))
				rd_nxt = {15'h0000, status_r};
			else if (idx == idx_of(OFS_MASK))
				rd_nxt = {15'h0000, mask_r};
			else
				rd_nxt = {24'h000000, regs_r[idx]};
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			prdata_r <= 32'h00000000;
		else if (setup && !pwrite_in)
			prdata_r <= rd_nxt;
	end

	//--------------------------------------------------
	// interrupt-on-change and external interrupt
	//--------------------------------------------------
	logic [15:0] chg16;
	logic [15:0] rise16;
	logic [15:0] ioc_set;
	logic ext_set;
	logic [16:0] stat_clr;

	change_detect #(
		.WIDTH(16)
	) u_change (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.level_in(pin16),
		.change_out(chg16),
		.rise_out(rise16)
	);

	// open-drain pins keep change detection; reset pin does not
	assign ioc_set = chg16 & iocen16 &
		~(master_clear_enable_bit ? INPUT_ONLY_MASK : 16'h0000);
	assign ext_set = opt_q[OPT_EXT_INTERRUPT_ENABLE_BIT_BIT] && rise16[PIN_T0];
	assign stat_clr = (wr && idx == idx_of(OFS_STAT)) ?
		pwdata_in[16:0] : STAT_RESET;

	// write one to clear; a new event in the same cycle wins
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			status_r <= STAT_RESET;
		else
			status_r <= (status_r & ~stat_clr) | {ext_set, ioc_set};
	end

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			mask_r <= STAT_RESET;
		else if (wr && idx == idx_of(OFS_MASK))
			mask_r <= pwdata_in[16:0];
	end

	assign irq_out = |(status_r & mask_r);

	//--------------------------------------------------
	// alternate function claims
	//--------------------------------------------------
	logic [15:0] alt_en;
	logic [15:0] alt_val;
	logic [15:0] hold;
	logic [15:0] out16;
	logic [15:0] oe_n16;

	// analog claims only release the digital driver
	always_comb
	begin
		alt_en = 16'h0000;
		alt_val = 16'h0000;
		hold = INPUT_ONLY_MASK;
		if (dbg_en && dbg_analog)
			hold[PIN_DBG] = 1'b1;
		else if (dbg_en)
		begin
			alt_en[PIN_DBG] = 1'b1;
			alt_val[PIN_DBG] = debug_digital_in[dbg_q[DBG_SEL_LSB +: 4]];
		end
		if (master)
		begin
			alt_en[PIN_SYNC] = 1'b1;
			alt_val[PIN_SYNC] = sync_clock_gen_in;
			hold[PIN_VREF] = 1'b1;
		end
		if (slave)
			hold[PIN_SYNC] = 1'b1;
		// the engine owns the pad only once software made it an input
		if (twi && dir16[PIN_SCL])
		begin
			alt_en[PIN_SCL] = 1'b1;
			alt_val[PIN_SCL] = !scl_drive_low_in;
		end
		if (twi && dir16[PIN_SDA])
		begin
			alt_en[PIN_SDA] = 1'b1;
			alt_val[PIN_SDA] = !sda_drive_low_in;
		end
	end

	for (genvar i = 0; i < 16; i++)
	begin : g_pin
		pin_drive_cell u_cell (
			.dir_in(dir16[i]),
			.data_in(data16[i]),
			.alt_en_in(alt_en[i]),
			.alt_val_in(alt_val[i]),
			.open_drain_in(OPEN_DRAIN_MASK[i]),
			.hold_off_in(hold[i]),
			.out_out(out16[i]),
			.oe_n_out(oe_n16[i])
		);
	end

	assign port_a_pin_out = out16[7:0];
	assign port_b_pin_out = out16[15:8];
	assign port_a_pin_oe_n_out = oe_n16[7:0];
	assign port_b_pin_oe_n_out = oe_n16[15:8];
	// pull-up only while not driving, never on open-drain pads
	assign {port_b_pullup_out, port_a_pullup_out} =
		pu16 & oe_n16 & ~OPEN_DRAIN_MASK;

	//--------------------------------------------------
	// analog routing and side signals
	//--------------------------------------------------
	always_comb
	begin
		for (int c = 0; c < 8; c++)
			adc_channel_connect_out[c] = dir16[CHAN_PIN[c]] &&
				ans16[CHAN_PIN[c]];
	end

	assign second_reference_output_out = master;
	assign debug_analog_connect_out = dbg_en && dbg_analog;
	assign debug_analog_source_out = regs_r[idx_of(OFS_CONV)]
		[CONV_SRC_LSB +: 4];
	assign sync_clock_pin_recv_out = slave && pin16[PIN_SYNC];
	assign timer_zero_ext_clock_out = opt_q[OPT_TIMER_ZERO_SOURCE_BIT_BIT] &&
		pin16[PIN_T0];
	assign external_reset_input_out = master_clear_enable_bit && !pin16[PIN_EXTERNAL_RESET_INPUT];
	assign scl_level_out = pin16[PIN_SCL];
	assign sda_level_out = pin16[PIN_SDA];
	assign sense_input_pullup_out = pe1_q[PE1_SPU_BIT];
	// amplifier reaches the pad only when both other uses are off
	assign sense_amplifier_output_out = !pe1_q[PE1_DESAT_BIT] &&
		!pe1_q[PE1_FBRES_BIT];
	assign desaturation_positive_input_out =
		!sense_amplifier_output_out;

	//--------------------------------------------------
	// assertions
	//--------------------------------------------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_ana_write;
		wr && idx == idx_of(OFS_ANS_A) && pwdata_in[0] && dir16[0];
	endsequence

	sequence s_pin3_change;
		iocen16[3] && $changed(port_a_pin_in[3]) && $past(rst_n_in);
	endsequence

	a_dir_push_pull: assert property (
		!dir16[3] |-> !port_a_pin_oe_n_out[3] &&
		port_a_pin_out[3] == data16[3])
		else $error("port a pin 3 not driving its data");
	a_dir_input: assert property (
		dir16[3] |-> port_a_pin_oe_n_out[3])
		else $error("port a pin 3 driving while input");
	a_adc_gate: assert property (
		s_ana_write |=> adc_channel_connect_out[0])
		else $error("channel 0 not connected after analog select");
	a_ioc_flag: assert property (
		s_pin3_change |=> status_r[3] ##1 status_r[3] || $past(wr))
		else $error("change on pin 3 not flagged");
	a_od_low_only: assert property (
		!port_a_pin_out[7] && !port_b_pin_out[0] &&
		!port_a_pullup_out[7] && !port_b_pullup_out[0])
		else $error("open-drain pad driven high or pulled up");
	a_input_only: assert property (
		port_a_pin_oe_n_out[5] && $stable(port_a_pin_oe_n_out[5]))
		else $error("pin five output enabled");
	a_reset_pin: assert property (
		external_reset_input_out == (master_clear_enable_bit && !port_a_pin_in[5]))
		else $error("reset input not following pin five");
	a_debug_route: assert property (
		dbg_en && !dbg_analog |-> !port_a_pin_oe_n_out[0] &&
		port_a_pin_out[0] == debug_digital_in[dbg_q[7:4]])
		else $error("debug monitor not on pin zero");
	a_sync_master: assert property (
		master |-> !port_a_pin_oe_n_out[1] &&
		port_a_pin_out[1] == sync_clock_gen_in)
		else $error("sync clock not driven in master role");
	a_sync_slave: assert property (
		slave |-> port_a_pin_oe_n_out[1] &&
		sync_clock_pin_recv_out == port_a_pin_in[1])
		else $error("sync input not received in slave role");
	a_timer_clock: assert property (
		timer_zero_ext_clock_out == (opt_q[0] && port_a_pin_in[2]))
		else $error("timer clock routing wrong");
	a_ext_int: assert property (
		opt_q[OPT_EXT_INTERRUPT_ENABLE_BIT_BIT] && $rose(port_a_pin_in[2]) &&
		$past(rst_n_in) |=> status_r[STAT_EXT_BIT])
		else $error("external interrupt edge not flagged");
	a_set_wins: assert property (
		wr && idx == idx_of(OFS_STAT) && pwdata_in[3] && ioc_set[3]
		|=> status_r[3])
		else $error("event lost under clear");
	a_vref_release: assert property (
		master |-> port_b_pin_oe_n_out[1] && second_reference_output_out)
		else $error("second reference pin still driven");
	a_sense_route: assert property (
		sense_input_pullup_out == pe1_q[1] &&
		(sense_amplifier_output_out ^ desaturation_positive_input_out))
		else $error("sense pad routing wrong");
	a_alt_priority: assert property (
		master && !dir16[1] && !data16[1] && sync_clock_gen_in |->
		port_a_pin_out[1])
		else $error("port data overrode sync output");
endmodule // pin_function_select

// ### test/pad_board.sv
// board circuitry model seen by the port pads
`timescale 1ns/10ps
module pad_board
	import pin_function_pkg::*;
(
	// clock
	input wire logic clock_in,
	// device pad side
	input wire logic [15:0] pin_out_in,
	input wire logic [15:0] oe_n_in,
	input wire logic [15:0] pullup_in,
	// board drivers
	input wire logic [15:0] drive_in,
	input wire logic [15:0] drive_en_in,
	// resolved wire levels
	output logic [15:0] level_out
);
	logic [15:0] float_r = 16'h5555;
	// a floating line wanders so it never reads a stale value
	always @(posedge clock_in)
		float_r <= ~float_r;
	// resolve each wire; serial lines carry a board pull-up
	always_comb
	begin
		for (int i = 0; i < 16; i++)
		begin
			if (!oe_n_in[i])
				level_out[i] = pin_out_in[i];
			else if (drive_en_in[i])
				level_out[i] = drive_in[i];
			else if (pullup_in[i] || OPEN_DRAIN_MASK[i])
				level_out[i] = 1'b1;
			else
				level_out[i] = float_r[i];
		end
	end
endmodule // pad_board

// ### test/pin_function_select_tb_top.sv
// self-checking bench of the pin function selection block
`timescale 1ns/10ps
module pin_function_select_tb_top;
	import pin_function_pkg::*;
	// ------------------------------
	// signals
	// ------------------------------
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, w;
	logic pready, pslverr, err, irq, second_reference_output, dbg_an, sync_recv, t0clk;
	logic ext_rst, scl_lvl, sda_lvl, s_pu, s_amp, s_desat;
	logic [15:0] lvl, p_out, p_oe_n, p_pu, e;
	logic [7:0] adc, v;
	logic [3:0] dbg_src;
	logic [15:0] dbg_dig = 16'h0, drv = 16'h0, drv_en = 16'hFFFF;
	logic sync_gen = 1'b0, scl_low = 1'b0, sda_low = 1'b0;
	logic [31:0] seed = 32'h2B19;
	int fails = 0, num_checks = 0;
	// free-running bus clock
	always #12.5 clock_in = ~clock_in;
	// ------------------------------
	// design and board
	// ------------------------------
	pin_function_select pin_function_select_inst (.clock_in(clock_in),
		.rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.port_a_pin_in(lvl[7:0]), .port_a_pin_out(p_out[7:0]),
		.port_a_pin_oe_n_out(p_oe_n[7:0]), .port_a_pullup_out(p_pu[7:0]),
		.port_b_pin_in(lvl[15:8]), .port_b_pin_out(p_out[15:8]),
		.port_b_pin_oe_n_out(p_oe_n[15:8]), .port_b_pullup_out(p_pu[15:8]),
		.adc_channel_connect_out(adc), .second_reference_output_out(second_reference_output),
		.debug_analog_connect_out(dbg_an), .debug_analog_source_out(dbg_src),
		.debug_digital_in(dbg_dig), .sync_clock_gen_in(sync_gen),
		.sync_clock_pin_recv_out(sync_recv), .timer_zero_ext_clock_out(t0clk),
		.external_reset_input_out(ext_rst), .scl_drive_low_in(scl_low),
		.sda_drive_low_in(sda_low), .scl_level_out(scl_lvl),
		.sda_level_out(sda_lvl), .sense_input_pullup_out(s_pu),
		.sense_amplifier_output_out(s_amp),
		.desaturation_positive_input_out(s_desat), .irq_out(irq));
	pad_board pad_board_inst (.clock_in(clock_in), .pin_out_in(p_out),
		.oe_n_in(p_oe_n), .pullup_in(p_pu), .drive_in(drv),
		.drive_en_in(drv_en), .level_out(lvl));
	// ------------------------------
	// helpers
	// ------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// channel n closes only with direction and analog set on its pin
	function automatic logic [7:0] exp_adc(logic [15:0] d, logic [15:0] s);
		logic [7:0] e;
		for (int n = 0; n < 8; n++)
			e[n] = d[CHAN_PIN[n]] & s[CHAN_PIN[n]];
		return e;
	endfunction
	// amplifier reaches the pad only with comparator and resistor unused
	function automatic logic [1:0] exp_sense(logic [7:0] p);
		logic used;
		used = p[PE1_DESAT_BIT] | p[PE1_FBRES_BIT];
		return {~used, used};
	endfunction
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_pin(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; the answer is awaited, never assumed
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		do
			@(posedge clock_in);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic settle();
		@(posedge clock_in);
		#1;
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// hang guard, far beyond the few hundred cycles of the run
	initial
	begin
		#250000;
		fails++;
		complete_run();
	end
	// ------------------------------
	// scenarios
	// ------------------------------
	initial
	begin
		repeat (5) @(posedge clock_in);
		rst_n_in <= 1'b1;
		apb(0, OFS_DIR_A, 0);
		check_word(rd, 32'hFF);
		apb(0, OFS_STAT, 0);
		check_word(rd, 32'h0);
		check_pin(p_oe_n, 16'hFFFF);
		// random directions and data on both ports, all-output corner first
		for (int k = 0; k < 5; k++)
		begin
			w = rnd();
			v = (k == 0) ? 8'h00 : w[23:16];
			apb(1, OFS_DIR_A, v);
			apb(1, OFS_DIR_B, v);
			apb(1, OFS_DATA_A, w[7:0]);
			apb(1, OFS_DATA_B, w[15:8]);
			settle();
			// open-drain and input-only pads are checked on their own
			e = 16'hFE5F;
			check_pin(p_oe_n & e, {v, v} & e);
			e = e & ~{v, v};
			check_pin(p_out & e, w[15:0] & e);
			check_pin(p_oe_n[PIN_EXTERNAL_RESET_INPUT], 1);
		end
		// open-drain pin pulls low or releases, never pulled up
		apb(1, OFS_DIR_A, 8'h7F);
		apb(1, OFS_DIR_B, 8'hFF);
		apb(1, OFS_DATA_A, 8'h00);
		apb(1, OFS_PU_A, 8'hFF);
		apb(1, OFS_PU_B, 8'hFF);
		settle();
		check_pin({p_oe_n[7], p_out[7], p_pu[7]}, 0);
		apb(1, OFS_DATA_A, 8'h80);
		settle();
		check_pin({p_oe_n[7], p_pu[7]}, 2'h2);
		apb(1, OFS_DIR_A, 8'hFF);
		@(posedge clock_in);
		drv_en[4] <= 1'b0;
		settle();
		check_pin(p_pu, 16'hFE7F);
		check_pin(lvl[4], 1);
		@(posedge clock_in);
		drv_en[4] <= 1'b1;
		// analog channel routing
		for (int k = 0; k < 6; k++)
		begin
			w = rnd();
			apb(1, OFS_DIR_A, w[7:0]);
			apb(1, OFS_DIR_B, w[15:8]);
			apb(1, OFS_ANS_A, w[23:16]);
			apb(1, OFS_ANS_B, w[31:24]);
			apb(0, OFS_DIR_B, 0);
			check_word(rd, w[15:8]);
			check_pin(adc, exp_adc(w[15:0], w[31:16]));
		end
		apb(1, OFS_DIR_A, 8'hFF);
		apb(1, OFS_DIR_B, 8'hFF);
		apb(1, OFS_ANS_A, 8'hFF);
		apb(1, OFS_ANS_B, 8'hFF);
		settle();
		check_pin(adc, 8'hFF);
		apb(1, OFS_ANS_A, 0);
		apb(1, OFS_ANS_B, 0);
		// change interrupt, masked then cleared
		apb(1, OFS_IOC_A, 8'hFF);
		apb(1, OFS_MASK, 32'h8);
		@(posedge clock_in);
		drv[3] <= 1'b1;
		repeat (3) settle();
		apb(0, OFS_STAT, 0);
		check_word(rd, 32'h8);
		check_pin(irq, 1);
		apb(1, OFS_MASK, 0);
		settle();
		check_pin(irq, 0);
		// corner: the pin falls just before the clearing edge; set wins
		fork
			apb(1, OFS_STAT, 32'h8);
			begin
				repeat (2) @(posedge clock_in);
				drv[3] <= 1'b0;
			end
		join
		apb(0, OFS_STAT, 0);
		check_word(rd, 32'h8);
		apb(1, OFS_STAT, 32'h8);
		apb(0, OFS_STAT, 0);
		check_word(rd, 32'h0);
		// external interrupt on a rising pin two
		apb(1, OFS_OPT, 32'h2);
		apb(1, OFS_MASK, 32'h10000);
		@(posedge clock_in);
		drv[2] <= 1'b1;
		repeat (3) settle();
		apb(0, OFS_STAT, 0);
		check_word(rd, 32'h10004);
		check_pin(irq, 1);
		apb(1, OFS_STAT, 32'h10004);
		// timer clock, then master clear
		apb(1, OFS_OPT, 32'h1);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clock_in);
			drv[2] <= k[0];
			settle();
			check_pin(t0clk, k[0]);
		end
		apb(1, OFS_OPT, 32'h4);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clock_in);
			drv[5] <= k[0];
			settle();
			check_pin(ext_rst, !k[0]);
		end
		apb(0, OFS_PIN_A, 0);
		check_pin(rd[PIN_EXTERNAL_RESET_INPUT], 0);
		// every role code
		apb(1, OFS_DIR_A, 8'hFD);
		apb(1, OFS_DIR_B, 8'hFD);
		for (int r = 0; r < 4; r++)
		begin
			apb(1, OFS_MODE, r);
			@(posedge clock_in);
			w = rnd();
			sync_gen <= w[0];
			drv[1] <= w[1];
			settle();
			check_pin(second_reference_output, r == 1);
			check_pin(p_oe_n[PIN_VREF], r == 1);
			check_pin(sync_recv, (r == 2) & drv[1]);
			check_pin(p_oe_n[PIN_SYNC], r == 2);
			if (r == 1)
				check_pin(p_out[PIN_SYNC], sync_gen);
		end
		apb(1, OFS_MODE, 0);
		// debug monitor, digital then analog
		apb(1, OFS_DIR_A, 8'hFE);
		@(posedge clock_in);
		w = rnd();
		dbg_dig <= w[15:0];
		v = w[23:16];
		apb(1, OFS_DBG, {v[3:0], 4'h1});
		settle();
		check_pin({p_oe_n[0], p_out[0]}, dbg_dig[v[3:0]]);
		apb(1, OFS_CONV, v[7:4]);
		apb(1, OFS_DBG, 8'h03);
		settle();
		check_pin({dbg_an, dbg_src, p_oe_n[0]}, {1'b1, v[7:4], 1'b1});
		apb(1, OFS_DBG, 0);
		// sense pad controls, every combination
		for (int k = 0; k < 16; k++)
		begin
			apb(1, OFS_PE1, k);
			settle();
			check_pin(s_pu, k[PE1_SPU_BIT]);
			check_pin({s_amp, s_desat}, exp_sense(8'(k)));
		end
		// two-wire mode with the serial pins left as inputs
		apb(1, OFS_OPT, 32'h8);
		apb(1, OFS_DIR_A, 8'hFF);
		@(posedge clock_in);
		drv_en[PIN_SDA:PIN_SCL] <= 2'h0;
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clock_in);
			w = rnd();
			{scl_low, sda_low} <= w[1:0];
			settle();
			check_pin({p_oe_n[PIN_SDA], p_oe_n[PIN_SCL]},
				{!sda_low, !scl_low});
			check_pin({sda_lvl, scl_lvl}, {!sda_low, !scl_low});
		end
		// unmapped address is refused
		apb(0, 8'h4C, 0);
		check_word({err, rd[15:0]}, 32'h10000);
		complete_run();
	end
endmodule // pin_function_select_tb_top
